// *** delay_timer.sv ***
// Down counter that runs a programmed number of clock periods
`timescale 1ns/1ps
module delay_timer #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] load_value,
  output logic                  busy,
  output logic                  expire
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic             expire;
  } dt_state_type;

  dt_state_type s_r;
  dt_state_type s_nxt;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt        = s_r;
    s_nxt.expire = 1'b0;
    if (start) begin
      // Restart from the new value at every trigger
      s_nxt.cnt    = load_value;
      s_nxt.expire = (load_value == '0);
    end else if (s_r.cnt != '0) begin
      s_nxt.cnt    = s_r.cnt - {{(WIDTH-1){1'b0}}, 1'b1};
      s_nxt.expire = (s_r.cnt == {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy   = (s_r.cnt != '0);
  assign expire = s_r.expire;

endmodule

// *** diag_ctrl_pkg.sv ***
// Constants for the switch diagnostic control register bank
package diag_ctrl_pkg;

  // Byte addresses on the microprocessor port
  localparam int          ADDR_WIDTH      = 20;
  localparam logic [19:0] OFS_MOD_LOW     = 20'h0_0144;
  localparam logic [19:0] OFS_MODE_HIGH   = 20'h0_0145;
  localparam logic [19:0] OFS_PLL_RESET   = 20'h0_0146;
  localparam logic [19:0] OFS_RESERVED    = 20'h0_0147;
  localparam logic [19:0] OFS_INT_DIAG    = 20'h0_0148;
  localparam logic [19:0] OFS_GAP         = 20'h0_0149;
  localparam logic [19:0] OFS_CMD_LOW     = 20'h0_014a;
  localparam logic [19:0] OFS_CMD_HIGH    = 20'h0_014b;

  // Field positions
  localparam int          CARRY_BREAK_BIT = 5;
  localparam int          EXT_FRAME_BIT   = 4;
  localparam int          MODULO_EN_BIT   = 3;
  localparam int          PLL_TWO_BIT     = 2;
  localparam int          PLL_ONE_BIT     = 1;
  localparam int          DIAG_SEL_LSB    = 6;
  localparam int          CLK_ERR_LSB     = 4;
  localparam int          SYS_ERR_LSB     = 2;
  localparam int          GP0_BIT         = 1;
  localparam int          FG0_BIT         = 0;
  localparam int          DELAY_EN_LSB    = 4;

  // Field values
  localparam logic [1:0]  INT_MODE_DIAG   = 2'h1;
  localparam logic [3:0]  CMD_DELAY_ON    = 4'h1;
  localparam logic [7:0]  RESET_BYTE      = 8'h00;
  localparam logic [7:0]  READ_ZERO       = 8'h00;

  // Widths
  localparam int          SC_WIDTH        = 11;
  localparam int          GAP_WIDTH       = 8;
  localparam int          OFFSET_WIDTH    = 12;
  localparam int          CMD_COUNT       = 3;

  // Command slots
  localparam int          CMD_GO_CLOCKS   = 0;
  localparam int          CMD_CLEAR_FB    = 1;
  localparam int          CMD_FORCE_FB    = 2;

  // Idle level of the active-low frame reference pin
  localparam logic        FRAME_IDLE      = 1'b1;

endpackage

// *** state_counter.sv ***
// Eleven-bit state counter with carry break, modulo and external frame
`timescale 1ns/1ps
module state_counter (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        tick,
  input  wire logic        carry_break_enable,
  input  wire logic        modulo_count_enable,
  input  wire logic        external_frame_select,
  input  wire logic [10:0] modulo_value,
  input  wire logic        compat_frame_reference_n,
  output logic      [10:0] count,
  output logic             frame_pulse
);

  typedef struct packed {
    logic [10:0] count;
    logic        frame;
    logic        ext_prev;
  } sc_state_type;

  sc_state_type s_r;
  sc_state_type s_nxt;
  logic         ext_center;
  logic         wrap;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt          = s_r;
    s_nxt.ext_prev = compat_frame_reference_n;
    // Falling edge marks frame center, at any rate
    ext_center     = s_r.ext_prev & ~compat_frame_reference_n;
    wrap           = 1'b0;
    if (tick) begin
      if (carry_break_enable) begin
        // Three free segments, each wraps alone
        s_nxt.count[3:0]  = s_r.count[3:0] + 4'h1;
        s_nxt.count[7:4]  = s_r.count[7:4] + 4'h1;
        s_nxt.count[10:8] = s_r.count[10:8] + 3'h1;
      end else if (modulo_count_enable && s_r.count == modulo_value) begin
        s_nxt.count = '0;
        wrap        = 1'b1;
      end else begin
        s_nxt.count = s_r.count + 11'h001;
        wrap        = (s_r.count == 11'h7ff);
      end
    end
    s_nxt.frame = external_frame_select ? ext_center : wrap;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '{count: '0, frame: 1'b0, ext_prev: diag_ctrl_pkg::FRAME_IDLE};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign count       = s_r.count;
  assign frame_pulse = s_r.frame;

endmodule

// *** switch_diagnostic_control.sv ***
// Diagnostic control register bank of the TDM switch
`timescale 1ns/1ps
module switch_diagnostic_control (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [19:0] reg_addr,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_read_ack,
  input  wire logic        state_tick,
  input  wire logic        compat_frame_reference_n,
  output logic      [10:0] state_count,
  output logic             frame_pulse,
  output logic             pll_one_divider_reset,
  output logic             pll_two_divider_reset,
  input  wire logic [1:0]  clk_err_in,
  input  wire logic [1:0]  sys_err_in,
  input  wire logic        general_purpose_pin0_in,
  input  wire logic        frame_group_pin0_in,
  output logic      [1:0]  clk_err_to_ic,
  output logic      [1:0]  sys_err_to_ic,
  output logic             general_purpose_pin0_to_ic,
  output logic             frame_group_pin0_to_ic,
  input  wire logic        interrupt_released,
  output logic             system_interrupt_gap,
  input  wire logic        go_clocks_req,
  input  wire logic        clear_fallback_req,
  input  wire logic        force_fallback_req,
  output logic             go_clocks_exec,
  output logic             clear_fallback_exec,
  output logic             force_fallback_exec
);

  typedef struct packed {
    logic [7:0] mod_low;
    logic [5:0] mode_high;
    logic       pll_two;
    logic       pll_one;
    logic [7:0] int_diag;
    logic [7:0] gap;
    logic [7:0] ofs_low;
    logic [7:0] ofs_high;
    logic [7:0] rdata;
    logic       rack;
    logic [1:0] clk_err;
    logic [1:0] sys_err;
    logic       gp0;
    logic       fg0;
    logic [2:0] pend;
    logic [2:0] exec;
  } dc_state_type;

  dc_state_type s_r;
  dc_state_type s_nxt;

  logic        carry_break_enable;
  logic        external_frame_select;
  logic        modulo_count_enable;
  logic [10:0] modulo_value;
  logic [1:0]  interrupt_diag_select;
  logic        diag_mode;
  logic [3:0]  command_delay_enable;
  logic        delay_on;
  logic [11:0] command_offset;
  logic        cmd_expire;
  logic [2:0]  cmd_req;
  logic [2:0]  issue;

  ////////////////////////////////////////////////////////////////////////
  // Field decode
  assign carry_break_enable    = s_r.mode_high[diag_ctrl_pkg::CARRY_BREAK_BIT];
  assign external_frame_select = s_r.mode_high[diag_ctrl_pkg::EXT_FRAME_BIT];
  assign modulo_count_enable   = s_r.mode_high[diag_ctrl_pkg::MODULO_EN_BIT];
  assign modulo_value          = {s_r.mode_high[2:0], s_r.mod_low};
  assign interrupt_diag_select = s_r.int_diag[7:6];
  assign diag_mode             = (interrupt_diag_select == diag_ctrl_pkg::INT_MODE_DIAG);
  assign command_delay_enable  = s_r.ofs_high[7:4];
  assign delay_on              = (command_delay_enable == diag_ctrl_pkg::CMD_DELAY_ON);
  assign command_offset        = {s_r.ofs_high[3:0], s_r.ofs_low};
  assign cmd_req               = {force_fallback_req, clear_fallback_req, go_clocks_req};

  // Pending commands leave at the frame, or at offset expiry in delay mode
  assign issue = s_r.pend & {3{delay_on ? cmd_expire : frame_pulse}};

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt      = s_r;
    s_nxt.rack = 1'b0;
    if (reg_write) begin
      case (reg_addr)
        diag_ctrl_pkg::OFS_MOD_LOW: begin
          s_nxt.mod_low = reg_wdata;
        end
        diag_ctrl_pkg::OFS_MODE_HIGH: begin
          // Reserved top bits are not kept
          s_nxt.mode_high = reg_wdata[5:0];
        end
        diag_ctrl_pkg::OFS_PLL_RESET: begin
          s_nxt.pll_two = reg_wdata[diag_ctrl_pkg::PLL_TWO_BIT];
          s_nxt.pll_one = reg_wdata[diag_ctrl_pkg::PLL_ONE_BIT];
        end
        diag_ctrl_pkg::OFS_INT_DIAG: begin
          s_nxt.int_diag = reg_wdata;
        end
        diag_ctrl_pkg::OFS_GAP: begin
          s_nxt.gap = reg_wdata;
        end
        diag_ctrl_pkg::OFS_CMD_LOW: begin
          s_nxt.ofs_low = reg_wdata;
        end
        diag_ctrl_pkg::OFS_CMD_HIGH: begin
          s_nxt.ofs_high = reg_wdata;
        end
        default: begin
        end
      endcase
    end
    if (reg_read) begin
      s_nxt.rack = 1'b1;
      case (reg_addr)
        diag_ctrl_pkg::OFS_MOD_LOW: begin
          s_nxt.rdata = s_r.mod_low;
        end
        diag_ctrl_pkg::OFS_MODE_HIGH: begin
          s_nxt.rdata = {2'b00, s_r.mode_high};
        end
        diag_ctrl_pkg::OFS_PLL_RESET: begin
          s_nxt.rdata = {5'b0_0000, s_r.pll_two, s_r.pll_one, 1'b0};
        end
        diag_ctrl_pkg::OFS_INT_DIAG: begin
          s_nxt.rdata = s_r.int_diag;
        end
        diag_ctrl_pkg::OFS_GAP: begin
          s_nxt.rdata = s_r.gap;
        end
        diag_ctrl_pkg::OFS_CMD_LOW: begin
          s_nxt.rdata = s_r.ofs_low;
        end
        diag_ctrl_pkg::OFS_CMD_HIGH: begin
          s_nxt.rdata = s_r.ofs_high;
        end
        default: begin
          // Reserved byte and unmapped addresses
          s_nxt.rdata = diag_ctrl_pkg::READ_ZERO;
        end
      endcase
    end
    // Interrupt controller input selection
    if (diag_mode) begin
      s_nxt.clk_err = s_r.int_diag[5:4];
      s_nxt.sys_err = s_r.int_diag[3:2];
      s_nxt.gp0     = s_r.int_diag[diag_ctrl_pkg::GP0_BIT];
      s_nxt.fg0     = s_r.int_diag[diag_ctrl_pkg::FG0_BIT];
    end else begin
      s_nxt.clk_err = clk_err_in;
      s_nxt.sys_err = sys_err_in;
      s_nxt.gp0     = general_purpose_pin0_in;
      s_nxt.fg0     = frame_group_pin0_in;
    end
    // A request in the issue cycle stays pending
    s_nxt.pend = (s_r.pend & ~issue) | cmd_req;
    s_nxt.exec = issue;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  state_counter u_state_counter (
    .clk                      (clk),
    .srst                     (srst),
    .tick                     (state_tick),
    .carry_break_enable       (carry_break_enable),
    .modulo_count_enable      (modulo_count_enable),
    .external_frame_select    (external_frame_select),
    .modulo_value             (modulo_value),
    .compat_frame_reference_n (compat_frame_reference_n),
    .count                    (state_count),
    .frame_pulse              (frame_pulse)
  );

  // Deassertion gap of the system interrupt output
  delay_timer #(.WIDTH(diag_ctrl_pkg::GAP_WIDTH)) u_gap_timer (
    .clk        (clk),
    .srst       (srst),
    .start      (interrupt_released),
    .load_value (s_r.gap),
    .busy       (system_interrupt_gap),
    .expire     ()
  );

  // Offset from the frame boundary for clock commands
  delay_timer #(.WIDTH(diag_ctrl_pkg::OFFSET_WIDTH)) u_cmd_timer (
    .clk        (clk),
    .srst       (srst),
    .start      (frame_pulse & delay_on),
    .load_value (command_offset),
    .busy       (),
    .expire     (cmd_expire)
  );

  ////////////////////////////////////////////////////////////////////////
  assign reg_rdata                  = s_r.rdata;
  assign reg_read_ack               = s_r.rack;
  assign pll_one_divider_reset      = s_r.pll_one;
  assign pll_two_divider_reset      = s_r.pll_two;
  assign clk_err_to_ic              = s_r.clk_err;
  assign sys_err_to_ic              = s_r.sys_err;
  assign general_purpose_pin0_to_ic = s_r.gp0;
  assign frame_group_pin0_to_ic     = s_r.fg0;
  assign go_clocks_exec             = s_r.exec[diag_ctrl_pkg::CMD_GO_CLOCKS];
  assign clear_fallback_exec        = s_r.exec[diag_ctrl_pkg::CMD_CLEAR_FB];
  assign force_fallback_exec        = s_r.exec[diag_ctrl_pkg::CMD_FORCE_FB];

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_modulo_load;
    @(posedge clk) disable iff (srst)
    reg_write && reg_addr == diag_ctrl_pkg::OFS_MOD_LOW ##1 reg_read && reg_addr == diag_ctrl_pkg::OFS_MOD_LOW
      |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_modulo_load: assert property (p_modulo_load) else $error("modulo low byte lost");

  property p_carry_normal;
    @(posedge clk) disable iff (srst)
    state_tick && !carry_break_enable && !modulo_count_enable && state_count == 11'h00f
      |=> state_count == 11'h010;
  endproperty
  a_carry_normal: assert property (p_carry_normal) else $error("carry not propagated");

  property p_carry_break;
    @(posedge clk) disable iff (srst)
    state_tick && carry_break_enable && !reg_write
      |=> state_count[7:4] == 4'($past(state_count[7:4]) + 4'h1)
          && state_count[10:8] == 3'($past(state_count[10:8]) + 3'h1);
  endproperty
  a_carry_break: assert property (p_carry_break) else $error("segments not independent");

  property p_ext_frame;
    @(posedge clk) disable iff (srst)
    external_frame_select && $fell(compat_frame_reference_n) |=> frame_pulse;
  endproperty
  a_ext_frame: assert property (p_ext_frame) else $error("external frame center missed");

  property p_ext_only;
    @(posedge clk) disable iff (srst)
    external_frame_select && !$fell(compat_frame_reference_n) |=> !frame_pulse;
  endproperty
  a_ext_only: assert property (p_ext_only) else $error("frame without external center");

  property p_modulo_roll;
    @(posedge clk) disable iff (srst)
    state_tick && modulo_count_enable && !carry_break_enable && state_count == modulo_value
      |=> state_count == 11'h000;
  endproperty
  a_modulo_roll: assert property (p_modulo_roll) else $error("no modulo rollover");

  property p_reserved_bits;
    @(posedge clk) disable iff (srst)
    reg_read && reg_addr == diag_ctrl_pkg::OFS_MODE_HIGH |=> reg_rdata[7:6] == 2'b00;
  endproperty
  a_reserved_bits: assert property (p_reserved_bits) else $error("reserved bits read nonzero");

  property p_pll_reset;
    @(posedge clk) disable iff (srst)
    reg_write && reg_addr == diag_ctrl_pkg::OFS_PLL_RESET
      |=> pll_two_divider_reset == $past(reg_wdata[2]) && pll_one_divider_reset == $past(reg_wdata[1]);
  endproperty
  a_pll_reset: assert property (p_pll_reset) else $error("divider reset not applied");

  property p_normal_ic;
    @(posedge clk) disable iff (srst)
    !srst && !diag_mode |=> {clk_err_to_ic, sys_err_to_ic, general_purpose_pin0_to_ic, frame_group_pin0_to_ic}
                            == $past({clk_err_in, sys_err_in, general_purpose_pin0_in, frame_group_pin0_in});
  endproperty
  a_normal_ic: assert property (p_normal_ic) else $error("normal mode not transparent");

  property p_diag_ic;
    @(posedge clk) disable iff (srst)
    diag_mode |=> {clk_err_to_ic, sys_err_to_ic, general_purpose_pin0_to_ic, frame_group_pin0_to_ic}
                  == $past(s_r.int_diag[5:0]);
  endproperty
  a_diag_ic: assert property (p_diag_ic) else $error("diagnostic override wrong");

  property p_gap_two;
    @(posedge clk) disable iff (srst)
    interrupt_released && s_r.gap == 8'h02
      |=> system_interrupt_gap ##1 system_interrupt_gap ##1 !system_interrupt_gap;
  endproperty
  a_gap_two: assert property (p_gap_two) else $error("gap length wrong");

  property p_no_delay;
    @(posedge clk) disable iff (srst)
    !delay_on && frame_pulse && s_r.pend[0] |=> go_clocks_exec;
  endproperty
  a_no_delay: assert property (p_no_delay) else $error("command not issued at frame");

  property p_delayed;
    @(posedge clk) disable iff (srst)
    delay_on && frame_pulse && command_offset == 12'h003 && s_r.pend[0] && !reg_write
      |=> !go_clocks_exec [*4] ##1 go_clocks_exec;
  endproperty
  a_delayed: assert property (p_delayed) else $error("command offset not honoured");

  property p_reset_clear;
    @(posedge clk)
    srst |=> !pll_one_divider_reset && !pll_two_divider_reset && !system_interrupt_gap
             && s_r.int_diag == 8'h00 && s_r.ofs_high == 8'h00 && !reg_read_ack;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("fields not cleared at reset");

endmodule

// *** switch_diagnostic_control_bench.sv ***
// Self-checking bench for the switch diagnostic control register bank
`timescale 1ns/1ps
module switch_diagnostic_control_bench;
  logic        clk;
  logic        srst;
  logic [19:0] reg_addr;
  logic        reg_write;
  logic        reg_read;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        reg_read_ack;
  logic        state_tick;
  logic        compat_frame_reference_n;
  logic [10:0] state_count;
  logic        frame_pulse;
  logic        pll_one_divider_reset;
  logic        pll_two_divider_reset;
  logic [1:0]  clk_err_in;
  logic [1:0]  sys_err_in;
  logic        gp_in;
  logic        fg_in;
  logic [1:0]  clk_err_to_ic;
  logic [1:0]  sys_err_to_ic;
  logic        gp_to_ic;
  logic        fg_to_ic;
  logic        interrupt_released;
  logic        system_interrupt_gap;
  logic [2:0]  req;
  logic [2:0]  exec;
  int          mismatches;
  int          compares;

  switch_diagnostic_control switch_diagnostic_control_inst (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_read_ack(reg_read_ack), .state_tick(state_tick),
    .compat_frame_reference_n(compat_frame_reference_n), .state_count(state_count),
    .frame_pulse(frame_pulse), .pll_one_divider_reset(pll_one_divider_reset),
    .pll_two_divider_reset(pll_two_divider_reset), .clk_err_in(clk_err_in), .sys_err_in(sys_err_in),
    .general_purpose_pin0_in(gp_in), .frame_group_pin0_in(fg_in), .clk_err_to_ic(clk_err_to_ic),
    .sys_err_to_ic(sys_err_to_ic), .general_purpose_pin0_to_ic(gp_to_ic),
    .frame_group_pin0_to_ic(fg_to_ic), .interrupt_released(interrupt_released),
    .system_interrupt_gap(system_interrupt_gap), .go_clocks_req(req[0]),
    .clear_fallback_req(req[1]), .force_fallback_req(req[2]), .go_clocks_exec(exec[0]),
    .clear_fallback_exec(exec[1]), .force_fallback_exec(exec[2])
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic reset_dut;
    @(posedge clk) srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
  endtask

  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk) begin
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
    end
    @(posedge clk) reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [19:0] a, input logic [7:0] exp);
    @(posedge clk) begin
      reg_addr <= a;
      reg_read <= 1'b1;
    end
    @(posedge clk) reg_read <= 1'b0;
    #1;
    chk(16'(reg_read_ack), 16'h0001);
    chk(16'(reg_rdata), 16'(exp));
  endtask

  // n ticks; frame_pulse and count settle after return
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk) state_tick <= 1'b1;
      @(posedge clk) state_tick <= 1'b0;
    end
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_registers;
    logic [7:0] wd [8] = '{8'hA5, 8'hFF, 8'hFF, 8'hFF, 8'h55, 8'h3C, 8'h96, 8'hFF};
    logic [7:0] ex [8] = '{8'hA5, 8'h3F, 8'h06, 8'h00, 8'h55, 8'h3C, 8'h96, 8'hFF};
    // Write then read back in the very next cycle
    @(posedge clk) begin
      reg_addr  <= 20'h0_0144;
      reg_wdata <= 8'h5A;
      reg_write <= 1'b1;
    end
    @(posedge clk) begin
      reg_write <= 1'b0;
      reg_read  <= 1'b1;
    end
    @(posedge clk) reg_read <= 1'b0;
    #1;
    chk(16'(reg_rdata), 16'h005A);
    for (int i = 0; i < 8; i++) wr(20'h0_0144 + 20'(i), wd[i]);
    wr(20'h0_0150, 8'h12);
    for (int i = 0; i < 8; i++) rd(20'h0_0144 + 20'(i), ex[i]);
    rd(20'h0_0150, 8'h00);
    chk(16'({pll_two_divider_reset, pll_one_divider_reset}), 16'h0003);
    wr(20'h0_0146, 8'h04);
    #1;
    chk(16'({pll_two_divider_reset, pll_one_divider_reset}), 16'h0002);
    reset_dut();
    for (int i = 0; i < 8; i++) rd(20'h0_0144 + 20'(i), 8'h00);
    chk(16'({pll_two_divider_reset, pll_one_divider_reset}), 16'h0000);
  endtask

  task automatic test_counter;
    reset_dut();
    wr(20'h0_0144, 8'h02);
    wr(20'h0_0145, 8'h09);
    tick(16'h0102);
    chk(16'({frame_pulse, state_count}), 16'h0102);
    tick(1);
    chk(16'({frame_pulse, state_count}), 16'h0800);
    reset_dut();
    wr(20'h0_0145, 8'hC0);
    tick(17);
    chk(16'(state_count), 16'h0011);
    reset_dut();
    wr(20'h0_0145, 8'h20);
    tick(17);
    chk(16'(state_count), 16'h0111);
  endtask

  task automatic test_ext_frame(input logic sel);
    int seen;
    reset_dut();
    if (sel) wr(20'h0_0145, 8'h10);
    seen = 0;
    // Two centers close together, far above the normal frame rate
    repeat (2) begin
      @(posedge clk) compat_frame_reference_n <= 1'b0;
      repeat (3) begin
        @(posedge clk);
        #1;
        if (frame_pulse === 1'b1) seen++;
      end
      @(posedge clk) compat_frame_reference_n <= 1'b1;
    end
    chk(16'(seen), 16'(2 * sel));
  endtask

  task automatic test_int_override;
    reset_dut();
    @(posedge clk) {clk_err_in, sys_err_in, gp_in, fg_in} <= 6'h05;
    repeat (3) @(posedge clk);
    #1;
    chk(16'({clk_err_to_ic, sys_err_to_ic, gp_to_ic, fg_to_ic}), 16'h0005);
    wr(20'h0_0148, 8'h7A);
    repeat (2) @(posedge clk);
    #1;
    chk(16'({clk_err_to_ic, sys_err_to_ic, gp_to_ic, fg_to_ic}), 16'h003A);
    wr(20'h0_0148, 8'hBA);
    repeat (2) @(posedge clk);
    #1;
    chk(16'({clk_err_to_ic, sys_err_to_ic, gp_to_ic, fg_to_ic}), 16'h0005);
  endtask

  task automatic test_gap;
    reset_dut();
    wr(20'h0_0149, 8'h02);
    @(posedge clk) interrupt_released <= 1'b1;
    @(posedge clk) interrupt_released <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      #1;
      chk(16'(system_interrupt_gap), 16'(k < 2));
      @(posedge clk);
    end
  endtask

  // Delayed exec lands offset plus two clocks after the frame
  task automatic test_commands(input logic [7:0] lo, input logic [7:0] hi, input int exp);
    int n;
    reset_dut();
    wr(20'h0_0144, 8'h01);
    wr(20'h0_0145, 8'h08);
    wr(20'h0_014a, lo);
    wr(20'h0_014b, hi);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) req <= 3'(1 << i);
      @(posedge clk) req <= 3'h0;
      n = 0;
      do begin
        tick(1);
        n++;
      end while (frame_pulse !== 1'b1 && n < 8);
      n = 0;
      while (exec[i] !== 1'b1 && n < 400) begin
        @(posedge clk);
        #1;
        n++;
      end
      chk(16'(n), 16'(exp));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    reg_addr = 20'h0_0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_wdata = 8'h00;
    state_tick = 1'b0;
    compat_frame_reference_n = 1'b1;
    {clk_err_in, sys_err_in, gp_in, fg_in} = 6'h00;
    interrupt_released = 1'b0;
    req = 3'h0;
    mismatches = 0;
    compares = 0;
    reset_dut();
    test_registers();
    test_counter();
    test_ext_frame(1'b0);
    test_ext_frame(1'b1);
    test_int_override();
    test_gap();
    test_commands(8'h02, 8'h21, 1);
    test_commands(8'h02, 8'h11, 16'h0104);
    test_commands(8'h03, 8'h10, 5);
    conclude();
  end

  initial begin
    #2_000_000;
    mismatches++;
    conclude();
  end
endmodule
